// >>> hw/sfmr_cfg.svh
// Purpose: Offsets, field positions, reset values and counts of the
//          multi-lane read sequencer.
// Assumes: Included by bare name; definitions only.
// Notes:   Register offsets are byte addresses on a 32-bit APB.
`ifndef SFMR_CFG_SVH
`define SFMR_CFG_SVH

// Register byte offsets
`define SFMR_OFF_CTRL    12'h000
`define SFMR_OFF_DUMMY   12'h004
`define SFMR_OFF_STATUS  12'h008
`define SFMR_OFF_ADDR    12'h00c

// Control field width and reset value
`define SFMR_CTRL_W      6
`define SFMR_CTRL_RST    6'h00

// Dummy field positions, four bits each
`define SFMR_DUM_QUAD    0
`define SFMR_DUM_DIO     4
`define SFMR_DUM_OUT     8
`define SFMR_DUM_W       12
`define SFMR_DUM_RST     12'h846

// Opcodes
`define SFMR_OP_FAST     8'h0b
`define SFMR_OP_FAST4    8'h0c
`define SFMR_OP_QIO      8'heb
`define SFMR_OP_UID      8'h4b
`define SFMR_OP_INFO     8'h68
`define SFMR_OP_DIO      8'hbb
`define SFMR_OP_DIO4     8'hbc
`define SFMR_OP_DOUT     8'h3b
`define SFMR_OP_DOUT4    8'h3c
`define SFMR_OP_QOUT     8'h6b
`define SFMR_OP_QOUT4    8'h6c

// Phase lengths in serial clocks, and the mode nibble that arms continuous read
`define SFMR_QPI_OP_CLKS 6'd2
`define SFMR_SPI_OP_CLKS 6'd8
`define SFMR_MODE_CLKS   6'd4
`define SFMR_MODE_ARM    4'ha

`endif

// >>> hw/sfmr_pkg.sv
// Purpose: Types shared by the multi-lane read sequencer files.
// Assumes: Nothing beyond the tool's SystemVerilog support.
// Notes:   Constants live in sfmr_cfg.svh.
package sfmr_pkg;

  // Sequencer phases
  typedef enum logic [2:0] {
    SQ_OPCODE,
    SQ_ADDR,
    SQ_MODE,
    SQ_DUMMY,
    SQ_DATA,
    SQ_IGNORE
  } sfmr_state_t;

  // Software controls, bit 5 first
  typedef struct packed {
    logic pin_is_reset;
    logic dtr;
    logic qe;
    logic write_in_progress_flag;
    logic extended_addressing_flag;
    logic quad_peripheral_mode;
  } sfmr_ctrl_t;

  // Shape of an accepted read command
  typedef struct packed {
    logic       valid;
    logic       wide;
    logic       has_mode;
    logic [2:0] addr_lanes;
    logic [2:0] out_lanes;
    logic [3:0] dummy;
  } sfmr_prof_t;

  // Link pins after synchronising
  typedef struct packed {
    logic       sck;
    logic       cs_n;
    logic       hold_n;
    logic [3:0] io;
  } sfmr_pins_t;

endpackage

// >>> hw/sfmr_sync.sv
// Purpose: Two-flop synchroniser for a group of pin inputs.
// Assumes: Inputs are asynchronous to pclk.
// Notes:   Only the second stage leaves the module.
module sfmr_sync #(
  parameter int W = 7
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  initial begin
    if (W < 1) $error("sfmr_sync: width must be positive");
  end

  // Two stages, first read only by the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// >>> hw/sfmr_read_seq.sv
// Purpose: Device-side sequencer for multi-lane read commands of a
//          serial NOR flash, with pause support and APB controls.
// Assumes: mem_data shows the byte at mem_addr one pclk after it moves.
// Notes:   Link pins are sampled by pclk; sck must stay slow enough.
// Functional notes
// (R1) QUAD_PERIPHERAL_MODE 0Bh takes 3 or 4 address bytes by flag; 0Ch always 4.
// (R2) QUAD_PERIPHERAL_MODE fast read: all lanes, opcode 2, address 6/8, dummy 6 clocks.
// (R3) QUAD_PERIPHERAL_MODE read data leaves on four lanes at falling sck edges.
// (R4) Address starts anywhere, steps per byte, wraps to zero.
// (R5) Chip select high ends the read, stops output, drops state.
// (R6) Read commands are ignored while write in progress is set.
// (R7) QUAD_PERIPHERAL_MODE EBh, 4Bh, 68h reuse fast read; 4Bh and 68h 3-byte only.
// (R8) Pause low with sck low freezes; high with sck low resumes.
// (R9) While paused outputs float and inputs are ignored.
// (R10) No pause in DTR, with quad enable, or pin used as reset.
// (R11) BBh takes 3 or 4 address bytes by flag; BCh always 4.
// (R12) Two-lane address and dummy, io1 first; dummy default 4.
// (R13) Two-lane data on falling edges, msb on io1.
// (R14) Mode byte upper nibble 1010 arms continuous read, else leaves.
// (R15) Leaving continuous read needs full command; mode kept.
// (R16) Mode cycles count within dummy; four dummy means data next.
// (R17) Host gives enough dummy and floats the don't-care nibble.
// (R18) 3Bh/3Ch: single-lane request, dummy 8, data two lanes.
// (R19) 6Bh/6Ch: single-lane request, address by flag, four-lane data.
// (R20) Host sets quad enable before a four-lane output read.
// (R21) Four-lane data msb on io3 down to io0.
// (R22) Only address bits up to 25 are decoded.
// (R23) Dummy counts come from a software setting with defaults.
`include "sfmr_cfg.svh"

module sfmr_read_seq
  import sfmr_pkg::*;
#(
  parameter int ADDR_W = 26
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              sck,
  input  wire logic              cs_n,
  input  wire logic              hold_n,
  input  wire logic [3:0]        io_in,
  output logic      [3:0]        io_out,
  output logic      [3:0]        io_oe,
  output logic      [ADDR_W-1:0] mem_addr,
  input  wire logic [7:0]        mem_data
);

  initial begin
    if (ADDR_W < 24 || ADDR_W > 32)
      $error("sfmr_read_seq: ADDR_W must lie in 24..32");
  end

  sfmr_ctrl_t                ctrl;
  logic [`SFMR_DUM_W-1:0]    dcfg;
  sfmr_pins_t                pin;
  logic                      sck_d;
  logic                      paused;
  logic                      cont;
  sfmr_state_t               state;
  sfmr_prof_t                prof;
  logic [5:0]                cnt;
  logic [31:0]               sh;
  logic [3:0]                dtg;
  logic [7:0]                dsh;
  logic [3:0]                left;
  logic                      drv;

  sfmr_state_t               next_state;
  sfmr_prof_t                next_prof;
  logic [5:0]                next_cnt;
  logic [31:0]               next_sh;
  logic [3:0]                next_dtg;
  logic                      next_cont;
  logic [ADDR_W-1:0]         next_maddr;
  logic [7:0]                next_dsh;
  logic [3:0]                next_left;
  logic                      next_drv;
  logic [3:0]                next_out;
  logic                      next_paused;

  // Shift lanes into a word, highest lane first
  function automatic logic [31:0] shift_in(input logic [31:0] v,
                                           input logic [3:0]  io,
                                           input logic [2:0]  lanes);
    case (lanes)
      3'd4:    shift_in = {v[27:0], io};
      3'd2:    shift_in = {v[29:0], io[1:0]};
      default: shift_in = {v[30:0], io[0]};
    endcase
  endfunction

  // Command shape for an opcode in the current interface mode
  function automatic sfmr_prof_t decode(input logic [7:0] op,
                                        input sfmr_ctrl_t c,
                                        input logic [11:0] dc);
    sfmr_prof_t p;
    p = '0;
    if (c.quad_peripheral_mode) begin
      p.addr_lanes = 3'd4;
      p.out_lanes  = 3'd4;
      p.dummy      = dc[`SFMR_DUM_QUAD +: 4];
      case (op)
        `SFMR_OP_FAST,
        `SFMR_OP_QIO: begin // R1 R7
          p.valid = 1'b1;
          p.wide  = c.extended_addressing_flag;
        end
        `SFMR_OP_FAST4: begin // R1
          p.valid = 1'b1;
          p.wide  = 1'b1;
        end
        `SFMR_OP_UID,
        `SFMR_OP_INFO: p.valid = 1'b1; // R7
        default: p.valid = 1'b0;
      endcase
    end else begin
      case (op)
        `SFMR_OP_DIO, `SFMR_OP_DIO4: begin // R11 R12
          p.valid      = 1'b1;
          p.wide       = (op == `SFMR_OP_DIO4) | c.extended_addressing_flag;
          p.has_mode   = 1'b1;
          p.addr_lanes = 3'd2;
          p.out_lanes  = 3'd2;
          p.dummy      = dc[`SFMR_DUM_DIO +: 4];
        end
        `SFMR_OP_DOUT, `SFMR_OP_DOUT4: begin // R18
          p.valid      = 1'b1;
          p.wide       = (op == `SFMR_OP_DOUT4) | c.extended_addressing_flag;
          p.addr_lanes = 3'd1;
          p.out_lanes  = 3'd2;
          p.dummy      = dc[`SFMR_DUM_OUT +: 4];
        end
        `SFMR_OP_QOUT, `SFMR_OP_QOUT4: begin // R19
          p.valid      = 1'b1;
          p.wide       = (op == `SFMR_OP_QOUT4) | c.extended_addressing_flag;
          p.addr_lanes = 3'd1;
          p.out_lanes  = 3'd4;
          p.dummy      = dc[`SFMR_DUM_OUT +: 4];
        end
        default: p.valid = 1'b0;
      endcase
    end
    return p;
  endfunction

  // Pin synchroniser
  sfmr_sync #(
    .W ($bits(sfmr_pins_t))
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({sck, cs_n, hold_n, io_in}),
    .q       (pin)
  );

  // Link decoding
  wire         selected = ~pin.cs_n;
  wire         hold_ok  = ~ctrl.dtr & ~ctrl.qe & ~ctrl.pin_is_reset; // R10
  wire         rise     = pin.sck & ~sck_d & ~paused; // R9
  wire         fall     = ~pin.sck & sck_d & ~paused; // R9
  wire [5:0]   cnt_inc  = cnt + 6'd1;
  wire [2:0]   in_lanes = (state == SQ_OPCODE) ?
                          (ctrl.quad_peripheral_mode ? 3'd4 : 3'd1) : prof.addr_lanes;
  wire [5:0]   op_clks  = ctrl.quad_peripheral_mode ? `SFMR_QPI_OP_CLKS
                                   : `SFMR_SPI_OP_CLKS; // R2
  wire [5:0]   addr_clks = (prof.addr_lanes == 3'd4) ?
                             (prof.wide ? 6'd8 : 6'd6) :
                           (prof.addr_lanes == 3'd2) ?
                             (prof.wide ? 6'd16 : 6'd12) :
                             (prof.wide ? 6'd32 : 6'd24); // R2 R12
  wire [31:0]  sh_in    = shift_in(sh, pin.io, in_lanes);
  wire [7:0]   op_byte  = sh_in[7:0];
  sfmr_prof_t  dec;
  assign dec = decode(op_byte, ctrl, dcfg);
  // Dummy left after the mode byte, never below zero
  wire [3:0]   dtg_mode = (prof.dummy > 4'd4) ? prof.dummy - 4'd4
                                              : 4'd0; // R16
  wire         mode_arm = sh_in[7:4] == `SFMR_MODE_ARM; // R14
  wire [7:0]   byte_now = (left == 4'd0) ? mem_data : dsh;
  wire [3:0]   byte_left = (left == 4'd0) ? 4'd8 : left;
  wire [3:0]   oe_mask  = (prof.out_lanes == 3'd4) ? 4'hf : 4'h3;
  wire         drive    = selected & (state == SQ_DATA) & next_drv &
                          ~next_paused;

  // Pause tracking, follows the pin while sck is low; deselect or a disabled pause clears it at once
  always_comb begin
    if (!selected || !hold_ok) begin
      next_paused = 1'b0; // R5 R10
    end else if (!pin.sck) begin
      next_paused = ~pin.hold_n; // R8
    end else begin
      next_paused = paused;
    end
  end

  // Sequencer next state
  always_comb begin
    next_state = state;
    next_prof  = prof;
    next_cnt   = cnt;
    next_sh    = sh;
    next_dtg   = dtg;
    next_cont  = cont;
    next_maddr = mem_addr;
    next_dsh   = dsh;
    next_left  = left;
    next_drv   = drv;
    next_out   = io_out;
    if (!selected) begin
      // Deselect drops the command; continuous read skips the opcode
      next_cnt  = 6'd0; // R5
      next_sh   = 32'h0;
      next_left = 4'd0;
      next_drv  = 1'b0;
      if (cont) begin
        next_state = ctrl.write_in_progress_flag ? SQ_IGNORE : SQ_ADDR; // R6 R14
      end else begin
        next_state = SQ_OPCODE; // R15
      end
    end else if (rise) begin
      next_sh  = sh_in;
      next_cnt = cnt_inc;
      case (state)
        SQ_OPCODE: begin
          if (cnt_inc == op_clks) begin
            next_cnt  = 6'd0;
            next_sh   = 32'h0;
            next_prof = dec;
            next_state = (!dec.valid || ctrl.write_in_progress_flag) ? SQ_IGNORE
                                                  : SQ_ADDR; // R6
          end
        end
        SQ_ADDR: begin
          if (cnt_inc == addr_clks) begin
            next_cnt   = 6'd0;
            next_sh    = 32'h0;
            next_maddr = sh_in[ADDR_W-1:0]; // R22
            next_dtg   = prof.dummy; // R23
            if (prof.has_mode) begin
              next_state = SQ_MODE;
            end else if (prof.dummy == 4'd0) begin
              next_state = SQ_DATA;
            end else begin
              next_state = SQ_DUMMY;
            end
          end
        end
        SQ_MODE: begin
          if (cnt_inc == `SFMR_MODE_CLKS) begin
            next_cnt   = 6'd0;
            next_cont  = mode_arm; // R14
            next_dtg   = dtg_mode; // R16
            next_state = (dtg_mode == 4'd0) ? SQ_DATA : SQ_DUMMY;
          end
        end
        SQ_DUMMY: begin
          if (cnt_inc == {2'b00, dtg}) begin
            next_cnt   = 6'd0;
            next_state = SQ_DATA;
          end
        end
        default: next_cnt = cnt;
      endcase
    end else if (fall && state == SQ_DATA) begin
      // Next lane group out, fetch and step on byte boundary
      next_drv = 1'b1; // R3
      if (prof.out_lanes == 3'd4) begin
        next_out  = byte_now[7:4]; // R21
        next_dsh  = {byte_now[3:0], 4'h0};
        next_left = byte_left - 4'd4;
      end else begin
        next_out  = {2'b00, byte_now[7:6]}; // R13
        next_dsh  = {byte_now[5:0], 2'b00};
        next_left = byte_left - 4'd2;
      end
      if (left == 4'd0) begin
        next_maddr = mem_addr + 1'b1; // R4
      end
    end
  end

  // Link-side registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_d  <= 1'b0;
      paused <= 1'b0;
      state  <= SQ_OPCODE;
      prof   <= '0;
      cnt    <= 6'd0;
      sh     <= 32'h0;
      dtg    <= 4'd0;
    end else begin
      sck_d  <= pin.sck;
      paused <= next_paused; // R8
      state  <= next_state;
      prof   <= next_prof;
      cnt    <= next_cnt;
      sh     <= next_sh;
      dtg    <= next_dtg;
    end
  end

  // Data path and pin drivers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cont     <= 1'b0;
      mem_addr <= '0;
      dsh      <= 8'h00;
      left     <= 4'd0;
      drv      <= 1'b0;
      io_out   <= 4'h0;
      io_oe    <= 4'h0;
    end else begin
      cont     <= next_cont;
      mem_addr <= next_maddr;
      dsh      <= next_dsh;
      left     <= next_left;
      drv      <= next_drv;
      io_out   <= next_out;
      io_oe    <= drive ? oe_mask : 4'h0; // R5 R9
    end
  end

  // APB decode
  wire        setup    = psel & ~penable & ~pready;
  wire        wr_ok    = psel & penable & pready & pwrite & ~pslverr;
  wire        hit_ctrl = paddr == `SFMR_OFF_CTRL;
  wire        hit_dum  = paddr == `SFMR_OFF_DUMMY;
  wire        hit_stat = paddr == `SFMR_OFF_STATUS;
  wire        hit_addr = paddr == `SFMR_OFF_ADDR;
  wire        mapped   = hit_ctrl | hit_dum | hit_stat | hit_addr;
  wire [31:0] stat_word = {26'h0, selected, paused, cont, state};
  wire [31:0] rd_word  =
    hit_ctrl ? {26'h0, ctrl} :
    hit_dum  ? {20'h0, dcfg} :
    hit_stat ? stat_word :
    hit_addr ? {{(32-ADDR_W){1'b0}}, mem_addr} : 32'h0;

  // APB answer, one wait-free access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= setup ? rd_word : 32'h0;
    end
  end

  // Software controls and dummy settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `SFMR_CTRL_RST;
      dcfg <= `SFMR_DUM_RST; // R23
    end else if (wr_ok && hit_ctrl) begin
      ctrl <= pwdata[`SFMR_CTRL_W-1:0]; // R15
    end else if (wr_ok && hit_dum) begin
      dcfg <= pwdata[`SFMR_DUM_W-1:0]; // R23
    end
  end

endmodule

// >>> bench/sfmr_read_seq_checker.sv
// Purpose: Port checks of the multi-lane read sequencer.
// Assumes: Link pins reach the logic about three pclk late.
// Notes:   Control word is shadowed from APB writes.
`include "sfmr_cfg.svh"

module sfmr_checker
  import sfmr_pkg::*;
#(
  parameter int ADDR_W = 26
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              sck,
  input wire logic              cs_n,
  input wire logic              hold_n,
  input wire logic [3:0]        io_out,
  input wire logic [3:0]        io_oe,
  input wire logic [ADDR_W-1:0] mem_addr
);
  timeunit 1ns;
  timeprecision 1ps;

  sfmr_ctrl_t ctrl_q;
  logic       busy_frame;
  logic       ctrl_wr;
  logic       hold_ok;

  // Control write decode and pause availability
  assign ctrl_wr = psel && penable && pready && pwrite
                   && paddr == `SFMR_OFF_CTRL;
  assign hold_ok = !(ctrl_q.qe || ctrl_q.dtr || ctrl_q.pin_is_reset);

  // Shadow control; busy flag frozen while selected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= '0;
      busy_frame <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_wr ? sfmr_ctrl_t'(pwdata[5:0]) : ctrl_q;
      busy_frame <= cs_n ? ctrl_q.write_in_progress_flag : busy_frame;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence

  a_apb_answer:
    assert property (s_setup |=> s_answer)
    else $error("APB answer not one cycle after setup");
  a_apb_unmapped:
    assert property (pready && paddr > `SFMR_OFF_ADDR |-> pslverr
      && prdata == 32'h0)
    else $error("Unmapped access without error");
  a_apb_idle:
    assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("Read bus busy outside an answer");
  a_cs_release:
    assert property (cs_n [*6] |-> io_oe == 4'h0)
    else $error("Lanes driven while deselected");
  a_pause_float:
    assert property ((!hold_n && !cs_n && hold_ok) [*6] |-> io_oe == 4'h0)
    else $error("Lanes driven during pause");
  a_busy_quiet:
    assert property (busy_frame && !cs_n |-> io_oe == 4'h0)
    else $error("Read answered while busy");
  a_out_fall:
    assert property ($changed(io_out) && io_oe != 4'h0
      |-> !sck && $past(!sck, 2))
    else $error("Data lanes moved away from a falling sck");
  a_oe_start:
    assert property ($rose(io_oe != 4'h0) |-> !sck && $past(!sck, 2))
    else $error("Drive began away from a falling sck");
  a_oe_lanes:
    assert property (io_oe inside {4'h0, 4'h3, 4'hf})
    else $error("Odd lane enable pattern");
  a_addr_step:
    assert property (io_oe != 4'h0 && $past(io_oe) != 4'h0
      && $changed(mem_addr) |-> mem_addr == $past(mem_addr) + 1'b1)
    else $error("Array address did not step by one");
endmodule

bind sfmr_read_seq sfmr_checker #(.ADDR_W(ADDR_W)) sfmr_checker_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sck(sck), .cs_n(cs_n),
  .hold_n(hold_n), .io_out(io_out), .io_oe(io_oe), .mem_addr(mem_addr)
);

// >>> bench/sfmr_host.sv
// Purpose: Host controller model for the flash link pins.
// Assumes: sck period is 16 pclk; mode 0, clock parked low.
// Notes:   Released lanes toggle each clock instead of holding.
module sfmr_host (
  input  wire logic       pclk,
  input  wire logic [3:0] io_w,
  output logic            sck,
  output logic            cs_n,
  output logic            hold_n,
  output logic [3:0]      drv
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] rx;

  // Idle pins at time zero
  initial begin
    sck    = 1'b0;
    cs_n   = 1'b1;
    hold_n = 1'b1;
    drv    = 4'h0;
    rx     = 32'h0;
  end

  // Shift groups MSB first, sample lanes before each rising sck
  task automatic shift(input logic [31:0] v, input int n, input int w,
                       input bit drive);
    logic [3:0] m;
    logic [3:0] g;
    m = 4'((1 << w) - 1);
    for (int k = 0; k < n; k++) begin
      g = v[31:28] >> (4 - w);
      v = v << w;
      @(posedge pclk);
      drv <= drive ? ((~drv & ~m) | g) : ~drv;
      // Low phase is eight pclk, counting the edge above
      repeat (7) @(posedge pclk);
      rx = (rx << w) | 32'(io_w & m);
      sck <= 1'b1;
      repeat (8) @(posedge pclk);
      sck <= 1'b0;
    end
  endtask

  // Select or deselect with sck low
  task automatic select(input bit on);
    @(posedge pclk);
    cs_n <= !on;
    repeat (8) @(posedge pclk);
  endtask

  // Pause pin moves only while sck is low
  task automatic pause(input bit on);
    @(posedge pclk);
    hold_n <= !on;
    repeat (4) @(posedge pclk);
  endtask
endmodule

// >>> bench/tb_sfmr_read_seq.sv
// Purpose: Self-checking bench of the multi-lane read sequencer.
// Assumes: Array byte is a fixed function of its address.
// Notes:   APB sets modes; the host model plays each frame.
`include "sfmr_cfg.svh"

`define CHK(nm, e, g) if ((g) !== (e)) begin \
  $display("FAIL %s exp %h got %h", nm, e, g); n_mismatch++; end \
  n_compared++;

module tb_sfmr_read_seq;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        sck, cs_n, hold_n;
  logic [3:0]  io_w, io_out, io_oe, drv;
  logic [25:0] mem_addr;
  logic [7:0]  mem_data;
  int          n_mismatch, n_compared, cyc;

  function automatic logic [7:0] mem_f(input logic [25:0] x);
    return x[7:0] ^ {6'h0, x[25:24]};
  endfunction

  // Wire level from both drivers; array answers one pclk later
  assign io_w = (io_out & io_oe) | (drv & ~io_oe);
  always #5 pclk = ~pclk;
  always @(posedge pclk) mem_data <= mem_f(mem_addr);

  sfmr_read_seq #(.ADDR_W(26)) sfmr_read_seq_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sck(sck), .cs_n(cs_n),
    .hold_n(hold_n), .io_in(io_w), .io_out(io_out), .io_oe(io_oe),
    .mem_addr(mem_addr), .mem_data(mem_data));

  sfmr_host sfmr_host_i (.pclk(pclk), .io_w(io_w), .sck(sck),
    .cs_n(cs_n), .hold_n(hold_n), .drv(drv));

  task automatic give_verdict;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Cut a hang short; the run needs well under this
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cfg(input logic [5:0] c, input logic [11:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, `SFMR_OFF_CTRL, 32'(c), q, e);
    apb(1'b1, `SFMR_OFF_DUMMY, 32'(d), q, e);
  endtask

  // One read frame; mb < 0 means no mode byte, dw 0 means no answer
  task automatic frame(input logic [7:0] op, input int ow, input int nb,
      input logic [31:0] a, input int aw, input int mb, input int dum,
      input int dw, input int hp, input int e2);
    logic [25:0] e;
    logic [3:0]  m;
    logic [7:0]  b1;
    int          lw;
    e = nb == 3 ? 26'(a[23:0]) : a[25:0];
    m = dw ? 4'((1 << dw) - 1) : 4'h0;
    lw = dw ? dw : 4;
    sfmr_host_i.select(1'b1);
    if (ow) sfmr_host_i.shift({op, 24'h0}, 8 / ow, ow, 1'b1);
    sfmr_host_i.shift(a << (32 - 8 * nb), 8 * nb / aw, aw, 1'b1);
    if (mb >= 0) begin
      sfmr_host_i.shift(32'(mb) << 24, 4 / aw, aw, 1'b1);
      sfmr_host_i.shift(32'h0, 4 / aw, aw, 1'b0);
    end
    sfmr_host_i.shift(32'h0, dum, 4, 1'b0);
    sfmr_host_i.shift(32'h0, 8 / lw, lw, 1'b0);
    b1 = sfmr_host_i.rx[7:0];
    `CHK("lane enable", m, io_oe)
    if (hp) begin
      sfmr_host_i.pause(1'b1);
      sfmr_host_i.shift(32'h0, hp, lw, 1'b0);
      `CHK("pause enable", e2 == 1 ? 4'h0 : m, io_oe)
      sfmr_host_i.pause(1'b0);
    end
    sfmr_host_i.shift(32'h0, 8 / lw, lw, 1'b0);
    if (dw) begin
      `CHK("first byte", mem_f(e), b1)
      `CHK("next byte", mem_f(e + 26'(e2)), sfmr_host_i.rx[7:0])
    end
    sfmr_host_i.select(1'b0);
    `CHK("end enable", 4'h0, io_oe)
  endtask

  task automatic t_regs;
    logic [31:0] q;
    logic        e;
    apb(1'b0, `SFMR_OFF_CTRL, 32'h0, q, e);
    `CHK("ctrl reset", 32'h0, q)
    apb(1'b0, `SFMR_OFF_DUMMY, 32'h0, q, e);
    `CHK("dummy reset", 32'h846, q)
    apb(1'b0, 12'h010, 32'h0, q, e);
    `CHK("unmapped error", 1'b1, e)
    `CHK("unmapped data", 32'h0, q)
  endtask

  task automatic t_quad;
    logic [7:0] ops [6] = '{8'h0b, 8'h0b, 8'h0c, 8'heb, 8'h4b, 8'h68};
    int         nb;
    for (int i = 0; i < 6; i++) begin
      nb = (i == 1 || i == 2) ? 4 : 3;
      // Identifier reads get the wide flag yet must take three bytes
      cfg({4'h0, i == 1 || i > 3, 1'b1}, {8'h84, i == 5 ? 4'h3 : 4'h6});
      frame(ops[i], 4, nb, i == 2 ? 32'hffff_ffff : 32'hff12_34fe + i,
            4, -1, i == 5 ? 3 : 6, 4, 0, 1);
    end
  endtask

  task automatic t_dual;
    cfg(6'h00, 12'h846);
    frame(8'hbb, 1, 3, 32'h0000_1000, 2, 8'ha5, 0, 2, 0, 1);
    frame(8'h00, 0, 3, 32'h0000_2000, 2, 8'h00, 0, 2, 0, 1);
    frame(8'hbc, 1, 4, 32'h0100_30f0, 2, 8'hff, 0, 2, 0, 1);
  endtask

  task automatic t_out;
    cfg(6'h00, 12'h846);
    frame(8'h3b, 1, 3, 32'h0055_aa01, 1, -1, 8, 2, 4, 1);
    frame(8'h3c, 1, 4, 32'h0155_aa02, 1, -1, 8, 2, 0, 1);
    cfg(6'h0a, 12'h846);
    frame(8'h6b, 1, 4, 32'h03ff_ffff, 1, -1, 8, 4, 2, 2);
    cfg(6'h08, 12'h846);
    frame(8'h6c, 1, 4, 32'h0000_0010, 1, -1, 8, 4, 0, 1);
  endtask

  task automatic t_busy;
    cfg(6'h04, 12'h846);
    frame(8'h3b, 1, 3, 32'h0, 1, -1, 8, 0, 0, 1);
  endtask

  // Reset, then the scenarios in turn
  initial begin
    pclk    = 1'b0;
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h0;
    pwdata  = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_quad();
    t_dual();
    t_out();
    t_busy();
    give_verdict();
  end
endmodule
